// ==== hdl/pack_protection_config_regs.sv ====
// Notes on behaviour
// - cell code 000 is ten, 110 four
// - bypass: charger present clears thermal faults
// - bypass overrides heat recovery load wait
// - thermal enable off ignores temperature entirely
// - trip code gives 2.800 to 4.375 V
// - thermistor pulled low on overvoltage if enabled
// - hysteresis code 300 mV down to zero
// - delay code 0.50 to 2.25 s, quarter steps
// - two-wire slave 0010000, pointer never increments
`timescale 1ns/10ps
`default_nettype none
module pack_protection_config_regs #(
  parameter int MS_CYCLES = prot_cfg_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // two-wire bus pins
  input  wire logic        i_scl,
  input  wire logic        i_sda,
  output logic             o_sda_out,
  output logic             o_sda_oe_n,
  // protection state inputs
  input  wire logic [12:0] i_cell_mv_max,
  input  wire logic        i_temp_over,
  input  wire logic        i_temp_cooled,
  input  wire logic        i_charger_present,
  input  wire logic        i_load_removed,
  input  wire logic        i_current_fault_detect,
  // decoded configuration and fault states
  output logic [3:0]       o_cell_count,
  output logic             o_cell_count_invalid,
  output logic             o_thermal_sense_active,
  output logic             o_heat_fault,
  output logic             o_current_fault,
  output logic             o_cell_high_fault,
  // thermistor pin, open drain
  output logic             o_thermistor_pin_out,
  output logic             o_thermistor_pin_oe_n
);
  import prot_cfg_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR, ST_ACK_WR, ST_RD, ST_ACK_RD
  } bus_state_t;

  bus_state_t state_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic       scl_d_r;
  logic       sda_d_r;
  logic [2:0] bit_cnt_r;
  logic [7:0] shift_r;
  logic [7:0] tx_r;
  logic [7:0] ptr_r;
  logic       ptr_next_r;
  logic       read_r;
  logic       nack_r;
  logic       ack_phase_r;
  logic       sda_oe_n_r;
  logic       wr_en_r;
  logic [7:0] wr_data_r;
  logic [7:0] system_config_r;
  logic [7:0] trip_r;
  logic [7:0] hyst_delay_r;
  logic       heat_fault_r;
  logic       current_fault_r;
  logic       cell_high_fault;

  // pins pass two flops; the first is read only by the second
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r    <= 1'b1;
      sda_d_r    <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], i_scl};
      sda_sync_r <= {sda_sync_r[0], i_sda};
      scl_d_r    <= scl_sync_r[1];
      sda_d_r    <= sda_sync_r[1];
    end
  end

  wire scl_s    = scl_sync_r[1];
  wire sda_s    = sda_sync_r[1];
  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start    = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop     = scl_s && scl_d_r && !sda_d_r && sda_s;
  wire [7:0] rx_byte = {shift_r[6:0], sda_s};

  // register decode and read mux
  wire wr_sys  = wr_en_r && (ptr_r == SYSTEM_CONFIG_OFS);
  wire wr_trip = wr_en_r && (ptr_r == CELL_HIGH_TRIP_OFS);
  wire wr_hd   = wr_en_r && (ptr_r == CELL_HIGH_HD_OFS);
  // reserved bits are stored whole and read back unchanged
  wire [7:0] rd_data =
    (ptr_r == SYSTEM_CONFIG_OFS)  ? system_config_r :
    (ptr_r == CELL_HIGH_TRIP_OFS) ? trip_r :
    (ptr_r == CELL_HIGH_HD_OFS)   ? hyst_delay_r : UNMAPPED_READ;

  // general call never matches, so it is left unacknowledged
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r     <= ST_IDLE;
      bit_cnt_r   <= 3'h0;
      shift_r     <= 8'h00;
      tx_r        <= 8'h00;
      ptr_r       <= 8'h00;
      ptr_next_r  <= 1'b1;
      read_r      <= 1'b0;
      nack_r      <= 1'b1;
      ack_phase_r <= 1'b0;
      sda_oe_n_r  <= 1'b1;
      wr_en_r     <= 1'b0;
      wr_data_r   <= 8'h00;
    end else begin
      wr_en_r <= 1'b0;
      if (start) begin
        state_r    <= ST_ADDR;
        bit_cnt_r  <= 3'h0;
        ptr_next_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
      end else if (stop) begin
        state_r    <= ST_IDLE;
        sda_oe_n_r <= 1'b1;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_n_r <= 1'b1;
          end
          ST_ADDR: if (scl_rise) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              ack_phase_r <= 1'b0;
              read_r      <= sda_s;
              state_r     <= (shift_r[6:0] == SLAVE_ADDR) ?
                             ST_ACK_ADDR : ST_IDLE;
            end
          end
          ST_ACK_ADDR, ST_ACK_WR: if (scl_fall) begin
            if (!ack_phase_r) begin
              sda_oe_n_r  <= 1'b0;
              ack_phase_r <= 1'b1;
            end else begin
              ack_phase_r <= 1'b0;
              bit_cnt_r   <= 3'h0;
              if (state_r == ST_ACK_ADDR && read_r) begin
                tx_r       <= rd_data;
                sda_oe_n_r <= rd_data[7];
                state_r    <= ST_RD;
              end else begin
                sda_oe_n_r <= 1'b1;
                state_r    <= ST_WR;
              end
            end
          end
          ST_WR: if (scl_rise) begin
            shift_r   <= rx_byte;
            bit_cnt_r <= bit_cnt_r + 3'h1;
            if (bit_cnt_r == 3'h7) begin
              state_r     <= ST_ACK_WR;
              ack_phase_r <= 1'b0;
              // later bytes rewrite the same location
              if (ptr_next_r) begin
                ptr_r      <= rx_byte;
                ptr_next_r <= 1'b0;
              end else begin
                wr_en_r   <= 1'b1;
                wr_data_r <= rx_byte;
              end
            end
          end
          ST_RD: if (scl_fall) begin
            if (bit_cnt_r == 3'h7) begin
              sda_oe_n_r <= 1'b1;
              state_r    <= ST_ACK_RD;
            end else begin
              tx_r       <= {tx_r[6:0], 1'b0};
              sda_oe_n_r <= tx_r[6];
              bit_cnt_r  <= bit_cnt_r + 3'h1;
            end
          end
          ST_ACK_RD: begin
            if (scl_rise) begin
              nack_r <= sda_s;
            end
            if (scl_fall) begin
              if (!nack_r) begin
                tx_r       <= rd_data;
                sda_oe_n_r <= rd_data[7];
                bit_cnt_r  <= 3'h0;
                state_r    <= ST_RD;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      system_config_r    <= SYSTEM_CONFIG_RST;
      trip_r       <= CELL_HIGH_TRIP_RST;
      hyst_delay_r <= CELL_HIGH_HD_RST;
    end else begin
      if (wr_sys) system_config_r <= wr_data_r;
      if (wr_trip) trip_r <= wr_data_r;
      if (wr_hd) hyst_delay_r <= wr_data_r;
    end
  end

  // decoded fields
  wire [2:0] cell_code    = system_config_r[CELL_COUNT_LSB +: 3];
  wire       bypass       = system_config_r[BYPASS_BIT];
  wire       thermal_en   = system_config_r[THERMAL_EN_BIT];
  wire       heat_mode    = system_config_r[HEAT_MODE_BIT];
  wire       current_mode = system_config_r[CURRENT_MODE_BIT];
  wire       ts_signal    = hyst_delay_r[TS_SIGNAL_BIT];

  // code 111 is unsupported; report zero cells and flag it
  wire       cell_bad  = cell_code == CELL_COUNT_INVALID;
  wire [3:0] cell_cnt  = CELL_COUNT_MAX - {1'b0, cell_code};
  wire       bypassed  = bypass && i_charger_present;
  wire       therm_act = thermal_en && !bypassed;
  wire       heat_set  = therm_act && i_temp_over;
  wire       heat_clr  = bypassed || !thermal_en ||
                         (i_temp_cooled && (!heat_mode || i_load_removed));
  wire       heat_nxt  = heat_set || (heat_fault_r && !heat_clr);
  wire       cur_clr   = i_load_removed &&
                         (!current_mode || i_charger_present);
  wire       cur_nxt   = i_current_fault_detect ||
                         (current_fault_r && !cur_clr);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      heat_fault_r    <= 1'b0;
      current_fault_r <= 1'b0;
    end else begin
      heat_fault_r    <= heat_nxt;
      current_fault_r <= cur_nxt;
    end
  end

  cell_high_qualifier #(
    .MS_CYCLES    (MS_CYCLES)
  ) u_cell_high (
    .i_clk        (i_clk),
    .i_rst        (i_rst),
    .i_trip_code  (trip_r[TRIP_CODE_LSB +: 6]),
    .i_hyst_code  (hyst_delay_r[HYST_CODE_LSB +: 3]),
    .i_delay_code (hyst_delay_r[DELAY_CODE_LSB +: 3]),
    .i_cell_mv_max(i_cell_mv_max),
    .o_fault      (cell_high_fault)
  );

  assign o_sda_out              = 1'b0;
  assign o_sda_oe_n             = sda_oe_n_r;
  assign o_cell_count           = cell_bad ? 4'h0 : cell_cnt;
  assign o_cell_count_invalid   = cell_bad;
  assign o_thermal_sense_active = therm_act;
  assign o_heat_fault           = heat_fault_r;
  assign o_current_fault        = current_fault_r;
  assign o_cell_high_fault      = cell_high_fault;
  assign o_thermistor_pin_out   = 1'b0;
  assign o_thermistor_pin_oe_n  = !(ts_signal && cell_high_fault);

  property p_cell_count;
    @(posedge i_clk) disable iff (i_rst)
    wr_sys && (wr_data_r[7:5] == 3'h6) |=> o_cell_count == 4'h4;
  endproperty
  a_cell_count: assert property (p_cell_count)
    else $error("cell code 110 does not give four cells");

  property p_bypass_clear;
    @(posedge i_clk) disable iff (i_rst)
    bypass && i_charger_present && heat_fault_r |=> !heat_fault_r;
  endproperty
  a_bypass_clear: assert property (p_bypass_clear)
    else $error("thermal fault held with charger present");

  property p_bypass_priority;
    @(posedge i_clk) disable iff (i_rst)
    bypass && heat_mode && i_charger_present && !i_load_removed
      |-> !o_thermal_sense_active ##1 !heat_fault_r;
  endproperty
  a_bypass_priority: assert property (p_bypass_priority)
    else $error("heat recovery mode overrode charger bypass");

  property p_thermal_off;
    @(posedge i_clk) disable iff (i_rst)
    !thermal_en |=> !heat_fault_r;
  endproperty
  a_thermal_off: assert property (p_thermal_off)
    else $error("thermal fault with sensing disabled");

  property p_heat_wait_load;
    @(posedge i_clk) disable iff (i_rst)
    heat_fault_r && heat_mode && thermal_en && !bypassed
      && !i_load_removed |=> heat_fault_r;
  endproperty
  a_heat_wait_load: assert property (p_heat_wait_load)
    else $error("thermal fault left before load removal");

  property p_current_wait;
    @(posedge i_clk) disable iff (i_rst)
    current_fault_r && current_mode && !i_charger_present
      |=> current_fault_r;
  endproperty
  a_current_wait: assert property (p_current_wait)
    else $error("current fault cleared without charger");

  property p_pointer_fixed;
    @(posedge i_clk) disable iff (i_rst)
    wr_en_r |=> $stable(ptr_r) ##1 $stable(ptr_r);
  endproperty
  a_pointer_fixed: assert property (p_pointer_fixed)
    else $error("register pointer moved after a data write");

  property p_ts_unused;
    @(posedge i_clk) disable iff (i_rst)
    !ts_signal |-> o_thermistor_pin_oe_n;
  endproperty
  a_ts_unused: assert property (p_ts_unused)
    else $error("thermistor pin driven while signalling is off");
endmodule : pack_protection_config_regs
`default_nettype wire

// ==== hdl/prot_cfg_pkg.sv ====
package prot_cfg_pkg;
  // two-wire slave address and register offsets
  localparam logic [6:0] SLAVE_ADDR         = 7'h10;
  localparam logic [7:0] SYSTEM_CONFIG_OFS  = 8'h01;
  localparam logic [7:0] CELL_HIGH_TRIP_OFS = 8'h02;
  localparam logic [7:0] CELL_HIGH_HD_OFS   = 8'h03;
  localparam logic [7:0] UNMAPPED_READ      = 8'h00;
  // values held until software reprograms them
  localparam logic [7:0] SYSTEM_CONFIG_RST  = 8'h00;
  localparam logic [7:0] CELL_HIGH_TRIP_RST = 8'h00;
  localparam logic [7:0] CELL_HIGH_HD_RST   = 8'h00;
  // system_config fields
  localparam int CELL_COUNT_LSB    = 5;
  localparam int BYPASS_BIT        = 4;
  localparam int THERMAL_EN_BIT    = 3;
  localparam int HEAT_MODE_BIT     = 2;
  localparam int RESERVED_ZERO_BIT = 1;
  localparam int CURRENT_MODE_BIT  = 0;
  // cell_high registers fields
  localparam int TRIP_CODE_LSB     = 0;
  localparam int TS_SIGNAL_BIT     = 7;
  localparam int HYST_CODE_LSB     = 4;
  localparam int DELAY_CODE_LSB    = 0;
  // cell count decode
  localparam logic [2:0] CELL_COUNT_INVALID = 3'h7;
  localparam logic [3:0] CELL_COUNT_MAX     = 4'hA;
  // trip threshold in mV: base plus step per code
  localparam logic [12:0] TRIP_BASE_MV = 13'h0AF0;
  localparam logic [12:0] TRIP_STEP_MV = 13'h0019;
  localparam logic [12:0] HYST_MV [8] = '{13'h012C, 13'h00FA, 13'h00C8,
    13'h0096, 13'h0064, 13'h0032, 13'h0019, 13'h0000};
  // qualification delay in ms: base plus step per code
  localparam logic [11:0] DELAY_BASE_MS = 12'h1F4;
  localparam logic [11:0] DELAY_STEP_MS = 12'h0FA;
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int MS_CYCLES     = NS_PER_MS / CLK_PERIOD_NS;
endpackage : prot_cfg_pkg

// ==== hdl/cell_high_qualifier.sv ====
`timescale 1ns/10ps
`default_nettype none
module cell_high_qualifier #(
  parameter int MS_CYCLES = prot_cfg_pkg::MS_CYCLES
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  // decoded configuration
  input  wire logic [5:0]  i_trip_code,
  input  wire logic [2:0]  i_hyst_code,
  input  wire logic [2:0]  i_delay_code,
  // highest cell voltage in mV
  input  wire logic [12:0] i_cell_mv_max,
  // fault state
  output logic             o_fault
);
  import prot_cfg_pkg::*;

  localparam int TW = $clog2(MS_CYCLES + 1);

  logic [TW-1:0] tick_cnt_r;
  logic [11:0]   ms_cnt_r;
  logic          fault_r;

  wire [12:0] trip_mv    = TRIP_BASE_MV +
                           13'(TRIP_STEP_MV * {7'h00, i_trip_code});
  wire [12:0] release_mv = trip_mv - HYST_MV[i_hyst_code];
  wire [11:0] delay_ms   = DELAY_BASE_MS +
                           12'(DELAY_STEP_MS * {9'h000, i_delay_code});
  wire        above      = i_cell_mv_max >= trip_mv;
  wire        below_rel  = i_cell_mv_max < release_mv;
  wire        tick       = tick_cnt_r == TW'(MS_CYCLES - 1);
  // any dip below the trip restarts qualification from zero
  wire        qualifying = above && !fault_r;
  wire        done       = qualifying && (ms_cnt_r == delay_ms);
  wire        clr        = fault_r && below_rel;
  wire        fault_nxt  = done || (fault_r && !clr);

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= 12'h000;
    end else if (!qualifying || done) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= 12'h000;
    end else if (tick) begin
      tick_cnt_r <= '0;
      ms_cnt_r   <= ms_cnt_r + 12'h001;
    end else begin
      tick_cnt_r <= tick_cnt_r + TW'(1);
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fault_r <= 1'b0;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign o_fault = fault_r;

  property p_trip_needs_delay;
    @(posedge i_clk) disable iff (i_rst)
    $rose(fault_r) |-> $past(ms_cnt_r) == $past(delay_ms);
  endproperty
  a_trip_needs_delay: assert property (p_trip_needs_delay)
    else $error("cell high fault set before delay elapsed");

  property p_hold_above_release;
    @(posedge i_clk) disable iff (i_rst)
    fault_r && (i_cell_mv_max >= release_mv) |=> fault_r;
  endproperty
  a_hold_above_release: assert property (p_hold_above_release)
    else $error("cell high fault cleared above release level");

  property p_dip_restarts;
    @(posedge i_clk) disable iff (i_rst)
    !fault_r && !above |=> ms_cnt_r == 12'h000 && !fault_r;
  endproperty
  a_dip_restarts: assert property (p_dip_restarts)
    else $error("qualification did not restart below trip");

  property p_trip_level;
    @(posedge i_clk) disable iff (i_rst)
    (i_trip_code == 6'h3F) |-> trip_mv == 13'h1117;
  endproperty
  a_trip_level: assert property (p_trip_level)
    else $error("top trip code does not give 4375 mV");
endmodule : cell_high_qualifier
`default_nettype wire

// ==== tb/two_wire_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module two_wire_master (
  // clock
  input  wire logic       i_clk,
  // device pull-down on data
  input  wire logic       i_sda_oe_n,
  // bus wires
  output logic            o_scl,
  output logic            o_sda,
  // each byte read back
  output logic            o_rd_v,
  output logic [7:0]      o_rd_data
);
  logic sda_r;
  // pull-up: a released wire reads high
  assign o_sda = sda_r & i_sda_oe_n;
  initial begin
    o_scl     = 1'b1;
    sda_r     = 1'b1;
    o_rd_v    = 1'b0;
    o_rd_data = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask : tick
  // also a repeated start when entered with the clock low
  task automatic start_cond;
    @(posedge i_clk);
    sda_r <= 1'b1;
    tick(6);
    o_scl <= 1'b1;
    tick(6);
    sda_r <= 1'b0;
    tick(6);
    o_scl <= 1'b0;
    tick(3);
  endtask : start_cond
  task automatic stop_cond;
    sda_r <= 1'b0;
    tick(6);
    o_scl <= 1'b1;
    tick(6);
    sda_r <= 1'b1;
    tick(6);
  endtask : stop_cond
  // data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    sda_r <= b;
    tick(6);
    o_scl <= 1'b1;
    tick(6);
    s = o_sda;
    o_scl <= 1'b0;
    tick(3);
  endtask : bit_io
  task automatic put_byte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : put_byte
  task automatic get_byte(input logic last);
    logic       s;
    logic [7:0] d;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
    o_rd_data <= d;
    o_rd_v    <= 1'b1;
    tick(1);
    o_rd_v    <= 1'b0;
  endtask : get_byte
  // no auto-increment: every data byte lands on the one offset
  task automatic reg_write(input logic [6:0] a, input logic [7:0] ofs,
                           input logic [7:0] d, input int nd,
                           output logic ack);
    logic k;
    start_cond();
    put_byte({a, 1'b0}, ack);
    put_byte(ofs, k);
    for (int i = 0; i < nd; i++) put_byte(d, k);
    stop_cond();
  endtask : reg_write
  task automatic reg_read(input logic [6:0] a, input int n,
                          output logic ack);
    start_cond();
    put_byte({a, 1'b1}, ack);
    if (ack === 1'b0) begin
      for (int i = 0; i < n; i++) get_byte(i == n - 1);
    end
    stop_cond();
  endtask : reg_read
endmodule : two_wire_master
`default_nettype wire

// ==== tb/pack_protection_config_regs_test.sv ====
`timescale 1ns/10ps
`default_nettype none
module pack_protection_config_regs_test;
  import prot_cfg_pkg::*;
  localparam int MS = 4;
  logic        i_clk, i_rst, scl, sda, sda_oe_n, ts_oe_n, rd_v, ack, pv;
  logic        inval, tact, heat, curf, ovf, dwin;
  logic        sda_out, ts_out;
  logic [7:0]  rd_data, v;
  logic [12:0] mv;
  logic [4:0]  stim_r;
  logic [3:0]  cnt, psel;
  logic [5:0]  t;
  logic [2:0]  h;
  logic [15:0] exp_q[$];
  wire  [15:0] obs [9];
  int          fail_count, n_checks, seed, n, lim, thr;
  int          hy [8] = '{300, 250, 200, 150, 100, 50, 25, 0};
  assign obs[0] = {12'h000, cnt};
  assign obs[1] = {15'h0000, inval};
  assign obs[2] = {15'h0000, tact};
  assign obs[3] = {15'h0000, heat};
  assign obs[4] = {15'h0000, curf};
  assign obs[5] = {15'h0000, ovf};
  // pull-up on the pin: released reads high, driven reads the out value
  assign obs[6] = {15'h0000, ts_oe_n | ts_out};
  assign obs[7] = {15'h0000, ack};
  assign obs[8] = {15'h0000, dwin};
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  pack_protection_config_regs #(.MS_CYCLES(MS)) DUT (
    .i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
    .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n), .i_cell_mv_max(mv),
    .i_temp_over(stim_r[4]), .i_temp_cooled(stim_r[3]),
    .i_charger_present(stim_r[2]), .i_load_removed(stim_r[1]),
    .i_current_fault_detect(stim_r[0]), .o_cell_count(cnt),
    .o_cell_count_invalid(inval), .o_thermal_sense_active(tact),
    .o_heat_fault(heat), .o_current_fault(curf),
    .o_cell_high_fault(ovf), .o_thermistor_pin_out(ts_out),
    .o_thermistor_pin_oe_n(ts_oe_n));
  two_wire_master bus (.i_clk(i_clk), .i_sda_oe_n(sda_oe_n | sda_out),
    .o_scl(scl), .o_sda(sda), .o_rd_v(rd_v), .o_rd_data(rd_data));
  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] e);
    n_checks++;
    if (seen !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, seen);
    end
  endtask : check
  // outputs are looked at on the falling edge, long settled
  always @(negedge i_clk) begin
    if (rd_v) check("read byte", {8'h00, rd_data}, exp_q.pop_front());
    if (pv) check("port", obs[psel], exp_q.pop_front());
  end
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  task automatic probe(input logic [3:0] sel, input logic [15:0] e);
    exp_q.push_back(e);
    psel <= sel;
    pv   <= 1'b1;
    @(posedge i_clk);
    pv   <= 1'b0;
    // let one edge pass so a following probe never retoggles pv at once
    @(posedge i_clk);
  endtask : probe
  // write nd bytes, then read the same offset twice without a pointer
  task automatic acc(input logic [7:0] ofs, input logic [7:0] d,
                     input int nd, input logic [7:0] e);
    bus.reg_write(SLAVE_ADDR, ofs, d, nd, ack);
    probe(7, 0);
    exp_q.push_back({8'h00, e});
    exp_q.push_back({8'h00, e});
    bus.reg_read(SLAVE_ADDR, 2, ack);
  endtask : acc
  task automatic apply(input logic [4:0] s, input logic [3:0] sel,
                       input logic [15:0] e);
    stim_r <= s;
    repeat (2) @(posedge i_clk);
    probe(sel, e);
  endtask : apply
  initial begin
    repeat (99000) @(posedge i_clk);
    fail_count++;
    complete_run();
  end
  initial begin
    seed = 32'h1dda;
    fail_count = 0;
    n_checks = 0;
    i_rst = 1'b1;
    stim_r = 5'h00;
    mv = 13'h0000;
    pv = 1'b0;
    psel = 4'h0;
    dwin = 1'b0;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
    probe(0, 16'h000A);
    acc(SYSTEM_CONFIG_OFS, 8'h00, 0, SYSTEM_CONFIG_RST);
    acc(CELL_HIGH_TRIP_OFS, 8'h00, 0, CELL_HIGH_TRIP_RST);
    acc(CELL_HIGH_HD_OFS, 8'h00, 0, CELL_HIGH_HD_RST);
    acc(8'h05, 8'h5A, 1, UNMAPPED_READ);
    for (int i = 0; i < 2; i++) begin
      bus.reg_write(i ? 7'h11 : 7'h00, CELL_HIGH_TRIP_OFS, 8'h3F, 1, ack);
      probe(7, 1);
    end
    acc(CELL_HIGH_TRIP_OFS, 8'h00, 0, CELL_HIGH_TRIP_RST);
    $display("test bus access complete");
    for (int c = 0; c < 8; c++) begin
      // reserved bit one always written as zero
      v = {c[2:0], 5'($random(seed)) & 5'h1D};
      acc(SYSTEM_CONFIG_OFS, v, 1, v);
      probe(0, (c == 7) ? 16'h0000 : 16'(10 - c));
      probe(1, 16'(c == 7));
    end
    $display("test cell count complete");
    acc(SYSTEM_CONFIG_OFS, 8'h04, 1, 8'h04);
    apply(5'h10, 3, 0);
    probe(2, 0);
    acc(SYSTEM_CONFIG_OFS, 8'h0C, 1, 8'h0C);
    apply(5'h10, 3, 1);
    apply(5'h08, 3, 1);
    apply(5'h0A, 3, 0);
    acc(SYSTEM_CONFIG_OFS, 8'h08, 1, 8'h08);
    apply(5'h10, 3, 1);
    apply(5'h08, 3, 0);
    acc(SYSTEM_CONFIG_OFS, 8'h1C, 1, 8'h1C);
    apply(5'h10, 3, 1);
    apply(5'h14, 3, 0);
    probe(2, 0);
    $display("test thermal complete");
    acc(SYSTEM_CONFIG_OFS, 8'h00, 1, 8'h00);
    apply(5'h01, 4, 1);
    apply(5'h02, 4, 0);
    acc(SYSTEM_CONFIG_OFS, 8'h01, 1, 8'h01);
    apply(5'h01, 4, 1);
    apply(5'h02, 4, 1);
    apply(5'h06, 4, 0);
    $display("test current fault complete");
    for (int d = 0; d < 8; d++) begin
      // last pass pins the top of the trip range
      t = (d == 7) ? 6'h3F : 6'($random(seed));
      h = 3'($random(seed));
      thr = 2800 + 25 * t;
      lim = (500 + 250 * d) * MS;
      v = {2'($random(seed)), t};
      acc(CELL_HIGH_TRIP_OFS, v, 1, v);
      v = {d[0], h, 1'($random(seed)), d[2:0]};
      acc(CELL_HIGH_HD_OFS, v, 1, v);
      if (d == 0) begin
        mv <= 13'(thr - 1);
        repeat (lim + 20) @(posedge i_clk);
        probe(5, 0);
      end
      // a one-cycle dip must restart the qualification time
      mv <= 13'(thr);
      repeat (lim / 4) @(posedge i_clk);
      mv <= 13'(thr - 1);
      @(posedge i_clk);
      mv <= 13'(thr);
      for (n = 0; n < lim + 50 && ovf !== 1'b1; n++) @(negedge i_clk);
      if (n >= lim + 50) begin
        fail_count++;
        complete_run();
      end
      @(posedge i_clk);
      dwin = (n >= lim - 2 && n <= lim + 4);
      probe(8, 1);
      probe(6, {15'h0000, ~d[0]});
      mv <= 13'(thr - hy[h]);
      repeat (4) @(posedge i_clk);
      probe(5, 1);
      mv <= 13'(thr - hy[h] - 1);
      repeat (2) @(posedge i_clk);
      probe(5, 0);
      probe(6, 1);
      mv <= 13'h0000;
    end
    $display("test cell high complete");
    complete_run();
  end
endmodule : pack_protection_config_regs_test
`default_nettype wire
